// File: rtl/smp_policy.sv
// Switch MAC frame admission, collision and back-pressure policy with its registers
//
// How it works
// - Alternate back-off only on half-duplex ports
// - Length check drops mismatched short-type frames
// - Drop mode set: pause type or DA
// - Drop mode clear: pause type and DA
// - Aggressive back-off during half-duplex back pressure
// - Multicast excluded from storm count when set
// - Back pressure by carrier sense or collision
// - Fair mode may drop non-flow-controlled traffic
// - Unfair mode only pauses flow-controlled port
// - Sixteen collisions drop frame unless disabled
// - Jumbo limit up to 9000, overrides oversize
// - Oversize check off accepts up to 2000
// - Standard limits 1522 tagged, 1518 untagged
// - Short pass accepts 32 to 64 bytes
// - Otherwise frames under 64 bytes dropped
// - Pass setting forwards PAUSE frames unfiltered
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "smp_regs.svh"

module smp_policy
   import smp_pkg::*;
#(
   parameter int SLOT_CYC = `SMP_SLOT_CYC
)
(
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        resetn,
   // Register port
   input  wire logic [11:0] reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [7:0]  reg_rdata,
   // Received frame summary
   input  wire logic        frm_valid,
   input  wire logic [15:0] frm_len,
   input  wire logic        frm_tagged,
   input  wire logic [15:0] frm_type_len,
   input  wire logic [15:0] frm_data_len,
   input  wire logic [47:0] frm_da,
   input  wire logic        frm_bcast,
   input  wire logic        frm_mcast,
   // Admission verdict
   output logic             adm_valid,
   output logic             adm_pass,
   output logic      [2:0]  adm_reason,
   output logic             storm_count,
   // Egress contention
   input  wire logic        cont_active,
   output logic             fc_pause,
   output logic             nfc_drop,
   // Half-duplex transmit
   input  wire logic        port_half,
   input  wire logic        tx_start,
   input  wire logic        tx_col,
   input  wire logic        tx_done,
   output logic             tx_backoff,
   output logic             tx_retry,
   output logic             tx_drop,
   output logic      [4:0]  tx_col_cnt,
   // Back-pressure mode
   output logic             bp_carrier,
   output logic             bp_aggr
);

   logic [1:0]  rst_sync_q;
   logic        rst_n;
   smp_state_s  st_q;
   smp_state_s  st_d;
   logic [9:0]  slots;
   logic [4:0]  col_next;
   logic        alt_on;
   logic        aggr_on;
   logic [15:0] max_len;
   logic [15:0] jlim_eff;
   logic        pause_type;
   logic        pause_da;
   logic        fc_hit;
   logic        too_short;
   logic        too_long;
   logic        len_bad;
   logic [17:0] bo_load;
   logic        hit_ctrl_a;
   logic        hit_ctrl_b;
   logic        hit_passfc;
   logic        hit_jlim_hi;
   logic        hit_jlim_lo;
   logic        hit_status;
   logic [7:0]  status_word;
   logic [7:0]  rd_mux;
   logic        start_ok;
   logic        col_drop;
   logic        storm_hit;
   logic        bo_zero;
   logic        bo_last;

   // Reset released through two flops
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         rst_sync_q <= 2'b00;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   assign alt_on   = st_q.ctrl_a[`SMP_A_ALT_BO] & port_half;
   assign aggr_on  = st_q.ctrl_a[`SMP_A_AGGR_BO] & port_half;
   assign col_next = (st_q.col_cnt == 5'h1f) ? st_q.col_cnt : st_q.col_cnt + 5'h01;
   // Full-duplex ports never start a half-duplex attempt
   assign start_ok  = tx_start & port_half;
   assign col_drop  = (col_next >= `SMP_COL_LIMIT) & ~st_q.ctrl_b[`SMP_B_NO_EXC_DROP];
   assign storm_hit = frm_bcast | (frm_mcast & ~st_q.ctrl_b[`SMP_B_MC_EXCL]);

   smp_backoff u_backoff (
      .ref_clk     (ref_clk),
      .rst_n       (rst_n),
      .half_duplex (port_half),
      .alt_mode    (alt_on),
      .aggr_mode   (aggr_on),
      .attempt     (col_next),
      .slots       (slots)
   );

   assign bo_load = 18'(slots) * 18'(SLOT_CYC);
   assign bo_zero = bo_load == 18'h00000;
   assign bo_last = st_q.bo_cnt <= 18'h00001;

   // Address decode shared by the write and read paths
   always_comb begin
      hit_ctrl_a  = reg_addr == `SMP_OFF_CTRL_A;
      hit_ctrl_b  = reg_addr == `SMP_OFF_CTRL_B;
      hit_passfc  = reg_addr == `SMP_OFF_PASSFC;
      hit_jlim_hi = reg_addr == `SMP_OFF_JLIM_HI;
      hit_jlim_lo = reg_addr == `SMP_OFF_JLIM_LO;
      hit_status  = reg_addr == `SMP_OFF_STATUS;
   end

   assign status_word = {st_q.reason, st_q.col_cnt};

   // Unmapped addresses read as zero
   always_comb begin
      rd_mux = 8'h00;
      if (hit_ctrl_a) begin
         rd_mux = st_q.ctrl_a;
      end
      if (hit_ctrl_b) begin
         rd_mux = st_q.ctrl_b;
      end
      if (hit_passfc) begin
         rd_mux = st_q.passfc;
      end
      if (hit_jlim_hi) begin
         rd_mux = st_q.jlim[15:8];
      end
      if (hit_jlim_lo) begin
         rd_mux = st_q.jlim[7:0];
      end
      if (hit_status) begin
         rd_mux = status_word;
      end
   end

   // Frame checks
   always_comb begin
      // Programmed limit is clipped so jumbo never passes 9000
      jlim_eff = (st_q.jlim > `SMP_LEN_JUMBO_MAX) ? `SMP_LEN_JUMBO_MAX : st_q.jlim;
      if (st_q.ctrl_b[`SMP_B_JUMBO]) begin
         max_len = jlim_eff;
      end else if (st_q.ctrl_b[`SMP_B_NO_MAX_CHK]) begin
         max_len = `SMP_LEN_NO_MAX;
      end else if (frm_tagged) begin
         max_len = `SMP_LEN_TAGGED;
      end else begin
         max_len = `SMP_LEN_UNTAGGED;
      end
      too_long = frm_len > max_len;
      if (st_q.ctrl_b[`SMP_B_SHORT_PASS]) begin
         too_short = frm_len < `SMP_LEN_SHORT_MIN;
      end else begin
         too_short = frm_len < `SMP_LEN_STD_MIN;
      end
      len_bad = st_q.ctrl_a[`SMP_A_LEN_CHK]
                & (frm_type_len < `SMP_LEN_FIELD_MAX)
                & (frm_data_len != frm_type_len);
      pause_type = frm_type_len == `SMP_PAUSE_TYPE;
      pause_da   = frm_da == `SMP_PAUSE_DA;
      if (st_q.ctrl_a[`SMP_A_FC_EITHER]) begin
         fc_hit = pause_type | pause_da;
      end else begin
         fc_hit = pause_type & pause_da;
      end
      // Pass setting overrides either drop mode
      if (st_q.passfc[`SMP_PASSFC_BIT]) begin
         fc_hit = 1'b0;
      end
   end

   // Next state
   always_comb begin
      st_d           = st_q;
      st_d.rdata     = 8'h00;
      st_d.adm_valid = 1'b0;
      st_d.storm     = 1'b0;
      st_d.tx_drop   = 1'b0;
      st_d.tx_retry  = 1'b0;

      // Register writes; reserved bits of ctrl_a and ctrl_b are stored as written, passfc keeps only its pass bit
      if (reg_wr && hit_ctrl_a) begin
         st_d.ctrl_a = reg_wdata;
      end
      if (reg_wr && hit_ctrl_b) begin
         st_d.ctrl_b = reg_wdata;
      end
      if (reg_wr && hit_passfc) begin
         st_d.passfc = {7'h00, reg_wdata[`SMP_PASSFC_BIT]};
      end
      if (reg_wr && hit_jlim_hi) begin
         st_d.jlim[15:8] = reg_wdata;
      end
      if (reg_wr && hit_jlim_lo) begin
         st_d.jlim[7:0] = reg_wdata;
      end

      // Read data stands only in the cycle after the strobe
      if (reg_rd) begin
         st_d.rdata = rd_mux;
      end

      // Admission verdict, size faults reported first
      if (frm_valid) begin
         st_d.adm_valid = 1'b1;
         st_d.adm_pass  = 1'b0;
         if (too_short) begin
            st_d.reason = SMP_RSN_SHORT;
         end else if (too_long) begin
            st_d.reason = SMP_RSN_LONG;
         end else if (len_bad) begin
            st_d.reason = SMP_RSN_LEN_MISMATCH;
         end else if (fc_hit) begin
            st_d.reason = SMP_RSN_FLOW_CTL;
         end else begin
            st_d.reason   = SMP_RSN_OK;
            st_d.adm_pass = 1'b1;
         end
         st_d.storm = storm_hit;
      end

      // Contention: flow-controlled port is always paused
      st_d.fc_pause = cont_active;
      st_d.nfc_drop = cont_active & st_q.ctrl_b[`SMP_B_FAIR];

      // Half-duplex transmit attempts
      case (st_q.tx_st)
         SMP_TX_IDLE: begin
            if (start_ok) begin
               st_d.tx_st   = SMP_TX_ACTIVE;
               st_d.col_cnt = 5'h00;
            end
         end
         SMP_TX_ACTIVE: begin
            if (tx_done) begin
               st_d.tx_st = SMP_TX_IDLE;
            end else if (tx_col) begin
               st_d.col_cnt = col_next;
               if (col_drop) begin
                  st_d.tx_drop = 1'b1;
                  st_d.tx_st   = SMP_TX_IDLE;
               end else if (bo_zero) begin
                  st_d.tx_retry = 1'b1;
               end else begin
                  st_d.bo_cnt = bo_load;
                  st_d.tx_st  = SMP_TX_BACKOFF;
               end
            end
         end
         SMP_TX_BACKOFF: begin
            if (bo_last) begin
               st_d.bo_cnt   = 18'h00000;
               st_d.tx_retry = 1'b1;
               st_d.tx_st    = SMP_TX_ACTIVE;
            end else begin
               st_d.bo_cnt = st_q.bo_cnt - 18'h00001;
            end
         end
         default: begin
            st_d.tx_st = SMP_TX_IDLE;
         end
      endcase

      // A duplex change abandons any attempt in flight
      if (!port_half) begin
         st_d.tx_st  = SMP_TX_IDLE;
         st_d.bo_cnt = 18'h00000;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q.ctrl_a    <= `SMP_RST_CTRL_A;
         st_q.ctrl_b    <= `SMP_RST_CTRL_B;
         st_q.passfc    <= `SMP_RST_PASSFC;
         st_q.jlim      <= `SMP_RST_JLIM;
         st_q.rdata     <= 8'h00;
         st_q.adm_valid <= 1'b0;
         st_q.adm_pass  <= 1'b0;
         st_q.reason    <= SMP_RSN_OK;
         st_q.storm     <= 1'b0;
         st_q.tx_st     <= SMP_TX_IDLE;
         st_q.col_cnt   <= 5'h00;
         st_q.bo_cnt    <= 18'h00000;
         st_q.tx_drop   <= 1'b0;
         st_q.tx_retry  <= 1'b0;
         st_q.fc_pause  <= 1'b0;
         st_q.nfc_drop  <= 1'b0;
      end else begin
         st_q <= st_d;
      end
   end

   // Outputs
   assign reg_rdata   = st_q.rdata;
   assign adm_valid   = st_q.adm_valid;
   assign adm_pass    = st_q.adm_pass;
   assign adm_reason  = st_q.reason;
   assign storm_count = st_q.storm;
   assign fc_pause    = st_q.fc_pause;
   assign nfc_drop    = st_q.nfc_drop;
   assign tx_backoff  = st_q.tx_st == SMP_TX_BACKOFF;
   assign tx_retry    = st_q.tx_retry;
   assign tx_drop     = st_q.tx_drop;
   assign tx_col_cnt  = st_q.col_cnt;
   // Carrier-sense back pressure only means something on half duplex
   assign bp_carrier  = st_q.ctrl_b[`SMP_B_BP_CARRIER] & port_half;
   assign bp_aggr     = aggr_on;

endmodule : smp_policy
`default_nettype wire

// File: rtl/smp_regs.svh
// Register offsets, field positions, reset values and limits of the MAC policy block
`ifndef SMP_REGS_SVH
`define SMP_REGS_SVH

`define SMP_OFF_JLIM_HI   12'h308
`define SMP_OFF_JLIM_LO   12'h309
`define SMP_OFF_CTRL_A    12'h330
`define SMP_OFF_CTRL_B    12'h331
`define SMP_OFF_PASSFC    12'h334
`define SMP_OFF_STATUS    12'h33f

`define SMP_RST_CTRL_A    8'h04
`define SMP_RST_CTRL_B    8'hf0
`define SMP_RST_PASSFC    8'h00
`define SMP_RST_JLIM      16'h2328

`define SMP_A_ALT_BO      7
`define SMP_A_LEN_CHK     3
`define SMP_A_FC_EITHER   1
`define SMP_A_AGGR_BO     0
`define SMP_B_MC_EXCL     6
`define SMP_B_BP_CARRIER  5
`define SMP_B_FAIR        4
`define SMP_B_NO_EXC_DROP 3
`define SMP_B_JUMBO       2
`define SMP_B_NO_MAX_CHK  1
`define SMP_B_SHORT_PASS  0
`define SMP_PASSFC_BIT    0

`define SMP_LEN_FIELD_MAX 16'd1500
`define SMP_LEN_JUMBO_MAX 16'd9000
`define SMP_LEN_NO_MAX    16'd2000
`define SMP_LEN_TAGGED    16'd1522
`define SMP_LEN_UNTAGGED  16'd1518
`define SMP_LEN_SHORT_MIN 16'd32
`define SMP_LEN_STD_MIN   16'd64
`define SMP_PAUSE_TYPE    16'h8808
`define SMP_PAUSE_DA      48'h0180c2000001
`define SMP_COL_LIMIT     5'd16
`define SMP_EXP_STD_MAX   4'd10
`define SMP_EXP_ALT_MAX   4'd8
`define SMP_EXP_AGGR_MAX  4'd2

`define SMP_SLOT_NS       512
`define SMP_CLK_NS        4
`define SMP_SLOT_CYC      ((`SMP_SLOT_NS + `SMP_CLK_NS - 1) / `SMP_CLK_NS)

`endif

// File: rtl/smp_pkg.sv
// Types shared by the MAC policy block
`default_nettype none
package smp_pkg;

   typedef enum logic [2:0] {
      SMP_RSN_OK,
      SMP_RSN_SHORT,
      SMP_RSN_LONG,
      SMP_RSN_LEN_MISMATCH,
      SMP_RSN_FLOW_CTL
   } smp_reason_e;

   typedef enum logic [1:0] {
      SMP_TX_IDLE,
      SMP_TX_ACTIVE,
      SMP_TX_BACKOFF
   } smp_tx_e;

   typedef struct packed {
      logic [15:0] lfsr;
   } smp_bo_s;

   typedef struct packed {
      logic [7:0]  ctrl_a;
      logic [7:0]  ctrl_b;
      logic [7:0]  passfc;
      logic [15:0] jlim;
      logic [7:0]  rdata;
      logic        adm_valid;
      logic        adm_pass;
      smp_reason_e reason;
      logic        storm;
      smp_tx_e     tx_st;
      logic [4:0]  col_cnt;
      logic [17:0] bo_cnt;
      logic        tx_drop;
      logic        tx_retry;
      logic        fc_pause;
      logic        nfc_drop;
   } smp_state_s;

endpackage : smp_pkg
`default_nettype wire

// File: rtl/smp_backoff.sv
// Back-off slot picker: random slot count under standard, alternate or aggressive caps
`timescale 1ns/1ps
`default_nettype none
`include "smp_regs.svh"

module smp_backoff
   import smp_pkg::*;
(
   // Clock and reset
   input  wire logic       ref_clk,
   input  wire logic       rst_n,
   // Policy
   input  wire logic       half_duplex,
   input  wire logic       alt_mode,
   input  wire logic       aggr_mode,
   input  wire logic [4:0] attempt,
   // Result
   output logic      [9:0] slots
);

   smp_bo_s    st_q;
   smp_bo_s    st_d;
   logic [3:0] exp_n;
   logic [3:0] cap;
   logic [9:0] mask;

   always_comb begin
      st_d      = st_q;
      st_d.lfsr = {st_q.lfsr[14:0],
                   st_q.lfsr[15] ^ st_q.lfsr[14] ^ st_q.lfsr[12] ^ st_q.lfsr[3]};
      // Aggressive caps hardest so back pressure wins the medium quickly
      if (aggr_mode) begin
         cap = `SMP_EXP_AGGR_MAX;
      end else if (alt_mode) begin
         cap = `SMP_EXP_ALT_MAX;
      end else begin
         cap = `SMP_EXP_STD_MAX;
      end
      exp_n = (attempt > {1'b0, cap}) ? cap : attempt[3:0];
      mask  = 10'((11'h001 << exp_n) - 11'h001);
      // Full duplex never backs off
      slots = half_duplex ? (st_q.lfsr[9:0] & mask) : 10'h000;
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q.lfsr <= 16'hace1;
      end else begin
         st_q <= st_d;
      end
   end

endmodule : smp_backoff
`default_nettype wire

// File: tb/smp_policy_props.sv
// Port-level assertions for the MAC policy block
`timescale 1ns/1ps
`default_nettype none

module smp_policy_chk #(
   parameter int SLOT_CYC = 128
)
(
   // Clock and reset
   input wire logic       ref_clk,
   input wire logic       resetn,
   // Frame verdict
   input wire logic       frm_valid,
   input wire logic [15:0] frm_len,
   input wire logic       adm_valid,
   input wire logic       adm_pass,
   input wire logic [2:0] adm_reason,
   input wire logic       storm_count,
   // Contention
   input wire logic       cont_active,
   input wire logic       fc_pause,
   input wire logic       nfc_drop,
   // Half duplex
   input wire logic       port_half,
   input wire logic       tx_backoff,
   input wire logic       tx_retry,
   input wire logic       tx_drop,
   input wire logic [4:0] tx_col_cnt,
   input wire logic       bp_carrier,
   input wire logic       bp_aggr
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);

   a_verdict_delay: assert property (frm_valid |=> adm_valid)
      else $error("verdict missing");
   a_short_drop: assert property (
      frm_valid && frm_len < 16'd32 |=> adm_valid && !adm_pass && adm_reason == 3'd1)
      else $error("short frame kept");
   a_jumbo_cap: assert property (
      frm_valid && frm_len > 16'd9000 |=> !adm_pass && adm_reason == 3'd2)
      else $error("frame over cap kept");
   a_storm_verdict: assert property (storm_count |-> adm_valid)
      else $error("storm count without verdict");
   a_pause_follow: assert property (cont_active |=> fc_pause)
      else $error("no pause under contention");
   a_pause_idle: assert property (!cont_active |=> !fc_pause && !nfc_drop)
      else $error("pause or drop without contention");
   a_nfc_cause: assert property (nfc_drop |-> $past(cont_active) && fc_pause)
      else $error("drop without contention");
   a_bp_half: assert property (!port_half |-> !bp_carrier && !bp_aggr)
      else $error("back pressure on full duplex");
   a_backoff_half: assert property (tx_backoff |-> $past(port_half))
      else $error("back-off on full duplex");
   a_drop_count: assert property (tx_drop |-> tx_col_cnt >= 5'd16 && !tx_retry)
      else $error("early collision drop");
endmodule : smp_policy_chk

bind smp_policy smp_policy_chk #(.SLOT_CYC(SLOT_CYC)) smp_policy_chk_i (
   .ref_clk(ref_clk), .resetn(resetn), .frm_valid(frm_valid), .frm_len(frm_len),
   .adm_valid(adm_valid), .adm_pass(adm_pass), .adm_reason(adm_reason),
   .storm_count(storm_count), .cont_active(cont_active), .fc_pause(fc_pause),
   .nfc_drop(nfc_drop), .port_half(port_half), .tx_backoff(tx_backoff),
   .tx_retry(tx_retry), .tx_drop(tx_drop), .tx_col_cnt(tx_col_cnt),
   .bp_carrier(bp_carrier), .bp_aggr(bp_aggr));

`default_nettype wire

// File: tb/smp_station.sv
// Link partner station: starts a frame, collides a set number of times, then succeeds
`timescale 1ns/1ps
`default_nettype none

module smp_station (
   // Clock
   input  wire logic       ref_clk,
   // Bench control
   input  wire logic       go,
   input  wire logic [5:0] n_col,
   // Switch side
   input  wire logic       tx_retry,
   output logic            tx_start,
   output logic            tx_col,
   output logic            tx_done
);
   logic [5:0] left_q;

   initial {tx_start, tx_col, tx_done, left_q} = '0;

   always @(posedge ref_clk) begin
      tx_start <= go;
      tx_col   <= (tx_start || tx_retry) && left_q != 6'h00;
      tx_done  <= (tx_start || tx_retry) && left_q == 6'h00;
      if (go)
         left_q <= n_col;
      else if ((tx_start || tx_retry) && left_q != 6'h00)
         left_q <= left_q - 6'h01;
   end
endmodule : smp_station

`default_nettype wire

// File: tb/smp_policy_test.sv
// Self-checking bench of the MAC policy block
`timescale 1ns/1ps
`default_nettype none

module smp_policy_test;
   import smp_pkg::*;
   logic        ref_clk, resetn, reg_wr, reg_rd, frm_valid, frm_tagged;
   logic        frm_bcast, frm_mcast, cont_active, port_half, go, st;
   logic [11:0] reg_addr;
   logic [7:0]  reg_wdata, reg_rdata, rd;
   logic [15:0] frm_len, frm_type_len, frm_data_len;
   logic [47:0] frm_da;
   logic [5:0]  n_col;
   logic [4:0]  tx_col_cnt;
   logic [2:0]  adm_reason;
   logic        adm_valid, adm_pass, storm_count, fc_pause, nfc_drop, tx_start, tx_col, tx_done;
   logic        tx_backoff, tx_retry, tx_drop, bp_carrier, bp_aggr;
   int          n_errors = 0, comparisons = 0, cycles = 0;

   smp_policy #(.SLOT_CYC(2)) smp_policy_i (.ref_clk(ref_clk), .resetn(resetn),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .frm_valid(frm_valid), .frm_len(frm_len), .frm_tagged(frm_tagged),
      .frm_type_len(frm_type_len), .frm_data_len(frm_data_len), .frm_da(frm_da),
      .frm_bcast(frm_bcast), .frm_mcast(frm_mcast), .adm_valid(adm_valid), .adm_pass(adm_pass),
      .adm_reason(adm_reason), .storm_count(storm_count), .cont_active(cont_active),
      .fc_pause(fc_pause), .nfc_drop(nfc_drop), .port_half(port_half), .tx_start(tx_start),
      .tx_col(tx_col), .tx_done(tx_done), .tx_backoff(tx_backoff), .tx_retry(tx_retry),
      .tx_drop(tx_drop), .tx_col_cnt(tx_col_cnt), .bp_carrier(bp_carrier), .bp_aggr(bp_aggr));

   smp_station smp_station_i (.ref_clk(ref_clk), .go(go), .n_col(n_col), .tx_retry(tx_retry),
      .tx_start(tx_start), .tx_col(tx_col), .tx_done(tx_done));

   always #2 ref_clk = ~ref_clk;

   task automatic wrap_up;
      $display("errors %0d, comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : wrap_up

   // Guards against a hung handshake
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 90000) begin
         n_errors++;
         wrap_up();
      end
   end

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : check

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rd_reg(input logic [11:0] a);
      @(posedge ref_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 rd = reg_rdata;
   endtask : rd_reg

   // Read-modify-write keeps the reserved bits as they are
   task automatic setb(input logic [11:0] a, input int b, input logic v);
      rd_reg(a);
      rd[b] = v;
      wr(a, rd);
   endtask : setb

   // Expected verdict is {pass, reason}
   task automatic frame(input logic [15:0] len, input logic [3:0] exp, input logic tag = 0,
         input logic [15:0] tl = 16'h0800, input logic [15:0] dl = 16'h0000,
         input logic [47:0] da = 48'h020000000001, input logic [1:0] mb = 2'b00);
      @(posedge ref_clk);
      frm_valid    <= 1'b1;
      frm_len      <= len;
      frm_tagged   <= tag;
      frm_type_len <= tl;
      frm_data_len <= dl;
      frm_da       <= da;
      {frm_mcast, frm_bcast} <= mb;
      @(posedge ref_clk);
      frm_valid <= 1'b0;
      #1 st = storm_count;
      check({adm_valid, adm_pass, adm_reason}, {1'b1, exp});
   endtask : frame

   // Expected outcome is {dropped, collision count}
   task automatic run(input logic [5:0] n, input logic [5:0] exp);
      int i;
      @(posedge ref_clk);
      n_col <= n;
      go    <= 1'b1;
      @(posedge ref_clk);
      go <= 1'b0;
      for (i = 0; i < 30000; i++) begin
         @(posedge ref_clk);
         #1;
         if (tx_drop || tx_done)
            break;
      end
      if (i == 30000) begin
         n_errors++;
         $display("wrong value at %0t: transfer never ended", $time);
      end
      check({tx_drop, tx_col_cnt}, exp);
   endtask : run

   task automatic t_regs;
      rd_reg(12'h330);
      check(rd, 8'h04);
      rd_reg(12'h331);
      check(rd, 8'hf0);
      rd_reg(12'h300);
      check(rd, 8'h00);
      rd_reg(12'h308);
      check(rd, 8'h23);
      rd_reg(12'h309);
      check(rd, 8'h28);
   endtask : t_regs

   task automatic t_size;
      frame(16'd31, 4'h1);
      frame(16'd63, 4'h1);
      frame(16'd64, 4'h8);
      frame(16'd1518, 4'h8);
      frame(16'd1519, 4'h2);
      frame(16'd1522, 4'h8, 1'b1);
      frame(16'd1523, 4'h2, 1'b1);
      setb(12'h331, 0, 1'b1);
      frame(16'd32, 4'h8);
      frame(16'd63, 4'h8);
      frame(16'd31, 4'h1);
      setb(12'h331, 1, 1'b1);
      frame(16'd2000, 4'h8);
      frame(16'd2001, 4'h2);
      setb(12'h331, 2, 1'b1);
      frame(16'd9000, 4'h8);
      frame(16'd9001, 4'h2);
      wr(12'h308, 8'h0b);
      wr(12'h309, 8'hb8);
      frame(16'd3000, 4'h8);
      frame(16'd3001, 4'h2);
      wr(12'h308, 8'hff);
      frame(16'd9000, 4'h8);
      frame(16'd9001, 4'h2);
   endtask : t_size

   task automatic t_lenchk;
      frame(16'd100, 4'h8, .tl(16'd46), .dl(16'd40));
      setb(12'h330, 3, 1'b1);
      frame(16'd100, 4'h3, .tl(16'd46), .dl(16'd40));
      frame(16'd100, 4'h8, .tl(16'd46), .dl(16'd46));
      frame(16'd100, 4'h8, .tl(16'd1500), .dl(16'd40));
   endtask : t_lenchk

   task automatic t_fc;
      frame(16'd100, 4'h8, .tl(16'h8808));
      frame(16'd100, 4'h8, .da(48'h0180c2000001));
      frame(16'd100, 4'h4, .tl(16'h8808), .da(48'h0180c2000001));
      setb(12'h330, 1, 1'b1);
      frame(16'd100, 4'h4, .tl(16'h8808));
      frame(16'd100, 4'h4, .da(48'h0180c2000001));
      setb(12'h334, 0, 1'b1);
      frame(16'd100, 4'h8, .tl(16'h8808), .da(48'h0180c2000001));
      setb(12'h334, 0, 1'b0);
      frame(16'd100, 4'h4, .tl(16'h8808), .da(48'h0180c2000001));
   endtask : t_fc

   task automatic t_storm;
      frame(16'd100, 4'h8, .mb(2'b10));
      check(st, 1'b0);
      frame(16'd100, 4'h8, .mb(2'b01));
      check(st, 1'b1);
      setb(12'h331, 6, 1'b0);
      frame(16'd100, 4'h8, .mb(2'b10));
      check(st, 1'b1);
   endtask : t_storm

   task automatic t_cont;
      @(posedge ref_clk);
      cont_active <= 1'b1;
      repeat (2) @(posedge ref_clk);
      #1 check({fc_pause, nfc_drop}, 2'b11);
      setb(12'h331, 4, 1'b0);
      @(posedge ref_clk);
      #1 check({fc_pause, nfc_drop}, 2'b10);
      @(posedge ref_clk);
      cont_active <= 1'b0;
   endtask : t_cont

   task automatic t_half;
      check({bp_carrier, bp_aggr}, 2'b00);
      @(posedge ref_clk);
      port_half <= 1'b1;
      #1 check({bp_carrier, bp_aggr}, 2'b10);
      setb(12'h331, 5, 1'b0);
      setb(12'h330, 0, 1'b1);
      #1 check({bp_carrier, bp_aggr}, 2'b01);
      run(6'd16, 6'h30);
      rd_reg(12'h33f);
      check(rd, 8'h10);
      setb(12'h330, 7, 1'b1);
      setb(12'h331, 3, 1'b1);
      run(6'd17, 6'h11);
   endtask : t_half

   initial begin
      ref_clk = 1'b0;
      {resetn, reg_wr, reg_rd, frm_valid, frm_tagged, frm_bcast, frm_mcast} = '0;
      {cont_active, port_half, go, reg_addr, reg_wdata} = '0;
      {frm_len, frm_type_len, frm_data_len, frm_da, n_col} = '0;
      repeat (2) @(posedge ref_clk);
      resetn <= 1'b1;
      repeat (3) @(posedge ref_clk);
      t_regs();
      t_size();
      t_lenchk();
      t_fc();
      t_storm();
      t_cont();
      t_half();
      wrap_up();
   end
endmodule : smp_policy_test

`default_nettype wire
